// ---- design/pllsel_top.sv ----
// Purpose: input loop feedback path, receiver mode and reference selection control
// Assumes: register port on mclk_in; pin and detector inputs are asynchronous
// Notes: all outputs registered; ce_in low freezes all state
// Function
// - zero delay select honoured only when feedback bit 0
// - internal mode powers down pin, feeds channel 0
// - external mode enables pin receiver, feeds pin
// - feedback bit 1 uses oscillator input receiver
// - zero delay differential bit picks differential reception
// - zero delay single-ended bit picks active pin
// - backup single-ended bit picks active pin
// - primary single-ended bit picks active pin
// - backup divider shares primary setting when set
// - force control voltage midsupply on clock failure
// - three-bit selection mode field, bits 4:2, reset 000
// - register mode codes nonrevert, revert, force primary, backup
// - top mode bit: select pin picks reference
// - backup single-ended select only when not differential
`timescale 1ns/1ns
module pllsel_top (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // register port
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // receiver mode bits held elsewhere
    input wire logic primary_diff_en_in,
    input wire logic backup_diff_en_in,
    // pins and detectors, asynchronous
    input wire logic ref_sel_pin_in,
    input wire logic primary_lost_in,
    input wire logic backup_lost_in,
    input wire logic clock_fail_in,
    // zero delay receiver and feedback
    output logic [1:0] fb_path_out,
    output logic zd_rx_enable_out,
    output logic zd_rx_diff_out,
    output logic zd_se_pin_sel_out,
    // reference receivers
    output logic primary_se_pin_sel_out,
    output logic backup_diff_out,
    output logic backup_se_pin_sel_out,
    output logic backup_rdiv_share_out,
    // loop control
    output logic oscillator_control_midsupply_out,
    output logic active_backup_out
);
    logic [7:0] zd_rx_r;
    logic [7:0] misc_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    pllsel_pkg::pllsel_state_t state_r;
    pllsel_pkg::pllsel_state_t state_nxt;

    // register address match, shared by write and read decode
    function automatic logic addr_hit(input logic [9:0] addr, input logic [9:0] target);
        return addr == target;
    endfunction : addr_hit

    // single-ended pin select, held low while the receiver is differential
    function automatic logic se_pick(input logic diff_en, input logic sel_bit);
        return !diff_en && sel_bit;
    endfunction : se_pick

    // register port decode
    wire hit_zd = addr_hit(reg_addr_in, pllsel_pkg::ADDR_ZD_RX_MODE);
    wire hit_misc = addr_hit(reg_addr_in, pllsel_pkg::ADDR_MISC_CTRL);
    wire wr_zd = reg_wr_in && hit_zd;
    wire wr_misc = reg_wr_in && hit_misc;
    wire [7:0] zd_rx_wval = reg_wdata_in & pllsel_pkg::ZD_RX_MASK;
    wire [7:0] misc_wval = reg_wdata_in & pllsel_pkg::MISC_MASK;
    wire [7:0] rd_data = hit_zd ? zd_rx_r : hit_misc ? misc_r : 8'h00;

    // pins and detectors after two flops
    wire [3:0] async_bits = {clock_fail_in, backup_lost_in, primary_lost_in, ref_sel_pin_in};
    wire pin_s = sync2_r[0];
    wire pr_lost_s = sync2_r[1];
    wire bk_lost_s = sync2_r[2];
    wire fail_s = sync2_r[3];

    // register field decode
    wire fb_osc = zd_rx_r[pllsel_pkg::FB_OSC_BIT];
    wire zd_internal = zd_rx_r[pllsel_pkg::ZD_MODE_BIT];
    wire zd_diff = zd_rx_r[pllsel_pkg::ZD_DIFF_BIT];
    wire [2:0] sel_mode = misc_r[pllsel_pkg::SEL_MODE_HI:pllsel_pkg::SEL_MODE_LO];
    wire pin_mode = sel_mode[pllsel_pkg::SEL_PIN_BIT];
    wire revert_mode = (sel_mode == pllsel_pkg::SEL_REVERT);

    // automatic switching conditions
    wire go_backup = pr_lost_s && !bk_lost_s;
    wire go_primary = !pr_lost_s && (bk_lost_s || revert_mode);

    // output next values
    wire [1:0] fb_path_nxt = fb_osc ? pllsel_pkg::FB_PATH_OSC :
                             zd_internal ? pllsel_pkg::FB_PATH_INTERNAL :
                             pllsel_pkg::FB_PATH_ZD_EXT;
    wire zd_en_nxt = !fb_osc && !zd_internal;
    wire zd_diff_nxt = zd_diff;
    wire zd_se_nxt = se_pick(zd_diff, zd_rx_r[pllsel_pkg::ZD_SE_SEL_BIT]);
    wire pr_se_nxt = se_pick(primary_diff_en_in, zd_rx_r[pllsel_pkg::PR_SE_SEL_BIT]);
    wire bk_diff_nxt = backup_diff_en_in;
    wire bk_se_nxt = se_pick(backup_diff_en_in, zd_rx_r[pllsel_pkg::BK_SE_SEL_BIT]);
    wire rdiv_share_nxt = misc_r[pllsel_pkg::BK_RDIV_SHARE_BIT];
    wire midsupply_nxt = misc_r[pllsel_pkg::MIDSUPPLY_BIT] && fail_s;
    wire active_backup_nxt = (state_nxt == pllsel_pkg::PLLSEL_ON_BACKUP);

    always_comb begin
        state_nxt = state_r;
        if (pin_mode) begin
            state_nxt = pin_s ? pllsel_pkg::PLLSEL_ON_BACKUP : pllsel_pkg::PLLSEL_ON_PRIMARY;
        end else begin
            case (sel_mode)
                pllsel_pkg::SEL_FORCE_PRIMARY: state_nxt = pllsel_pkg::PLLSEL_ON_PRIMARY;
                pllsel_pkg::SEL_FORCE_BACKUP: state_nxt = pllsel_pkg::PLLSEL_ON_BACKUP;
                pllsel_pkg::SEL_NONREVERT, pllsel_pkg::SEL_REVERT: begin
                    case (state_r)
                        pllsel_pkg::PLLSEL_ON_PRIMARY: begin
                            if (go_backup) begin
                                state_nxt = pllsel_pkg::PLLSEL_ON_BACKUP;
                            end
                        end
                        pllsel_pkg::PLLSEL_ON_BACKUP: begin
                            if (go_primary) begin
                                state_nxt = pllsel_pkg::PLLSEL_ON_PRIMARY;
                            end
                        end
                        default: state_nxt = pllsel_pkg::PLLSEL_ON_PRIMARY;
                    endcase
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    // two-flop synchroniser
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else if (ce_in) begin
            sync1_r <= async_bits;
            sync2_r <= sync1_r;
        end
    end

    // zero delay and receiver mode register
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            zd_rx_r <= pllsel_pkg::ZD_RX_RESET;
        end else if (ce_in && wr_zd) begin
            zd_rx_r <= zd_rx_wval;
        end
    end

    // input loop misc control register
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            misc_r <= pllsel_pkg::MISC_RESET;
        end else if (ce_in && wr_misc) begin
            misc_r <= misc_wval;
        end
    end

    // read data, held until the next read
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (ce_in && reg_rd_in) begin
            reg_rdata_out <= rd_data;
        end
    end

    // reference selection state
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= pllsel_pkg::PLLSEL_ON_PRIMARY;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // feedback path and zero delay receiver outputs
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fb_path_out <= pllsel_pkg::FB_PATH_ZD_EXT;
            zd_rx_enable_out <= 1'b1;
            zd_rx_diff_out <= 1'b0;
            zd_se_pin_sel_out <= 1'b0;
        end else if (ce_in) begin
            fb_path_out <= fb_path_nxt;
            zd_rx_enable_out <= zd_en_nxt;
            zd_rx_diff_out <= zd_diff_nxt;
            zd_se_pin_sel_out <= zd_se_nxt;
        end
    end

    // reference receiver outputs
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            primary_se_pin_sel_out <= 1'b0;
            backup_diff_out <= 1'b0;
            backup_se_pin_sel_out <= 1'b0;
            backup_rdiv_share_out <= 1'b0;
        end else if (ce_in) begin
            primary_se_pin_sel_out <= pr_se_nxt;
            backup_diff_out <= bk_diff_nxt;
            backup_se_pin_sel_out <= bk_se_nxt;
            backup_rdiv_share_out <= rdiv_share_nxt;
        end
    end

    // loop control outputs
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oscillator_control_midsupply_out <= 1'b0;
            active_backup_out <= 1'b0;
        end else if (ce_in) begin
            oscillator_control_midsupply_out <= midsupply_nxt;
            active_backup_out <= active_backup_nxt;
        end
    end
endmodule : pllsel_top

// ---- design/pllsel_pkg.sv ----
// Purpose: constants for the input loop reference and feedback selection block
// Assumes: 10-bit register addresses, 8-bit register data
// Notes: reserved bits are not stored and read as zero
package pllsel_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam logic [9:0] ADDR_ZD_RX_MODE = 10'h01b;
    localparam logic [9:0] ADDR_MISC_CTRL = 10'h01c;
    // zero_delay_and_receiver_mode fields
    localparam int ZD_MODE_BIT = 5;
    localparam int FB_OSC_BIT = 4;
    localparam int ZD_SE_SEL_BIT = 3;
    localparam int ZD_DIFF_BIT = 2;
    localparam int BK_SE_SEL_BIT = 1;
    localparam int PR_SE_SEL_BIT = 0;
    localparam logic [7:0] ZD_RX_MASK = 8'h3f;
    localparam logic [7:0] ZD_RX_RESET = 8'h00;
    // input_loop_misc_control fields
    localparam int BK_RDIV_SHARE_BIT = 7;
    localparam int MIDSUPPLY_BIT = 6;
    localparam int SEL_MODE_HI = 4;
    localparam int SEL_MODE_LO = 2;
    localparam logic [7:0] MISC_MASK = 8'hdc;
    localparam logic [7:0] MISC_RESET = 8'h00;
    // reference selection mode codes
    localparam logic [2:0] SEL_NONREVERT = 3'h0;
    localparam logic [2:0] SEL_REVERT = 3'h1;
    localparam logic [2:0] SEL_FORCE_PRIMARY = 3'h2;
    localparam logic [2:0] SEL_FORCE_BACKUP = 3'h3;
    localparam int SEL_PIN_BIT = 2;
    // feedback path encodings
    localparam logic [1:0] FB_PATH_OSC = 2'h0;
    localparam logic [1:0] FB_PATH_ZD_EXT = 2'h1;
    localparam logic [1:0] FB_PATH_INTERNAL = 2'h2;
    typedef enum logic {PLLSEL_ON_PRIMARY, PLLSEL_ON_BACKUP} pllsel_state_t;
endpackage : pllsel_pkg

// ---- sim/pllsel_monitor.sv ----
// Purpose: port checker for pllsel_top
// Assumes: ce_in high in the cycle after a register write
// Notes: attached to every pllsel_top by the bind below
`timescale 1ns/1ns
module pllsel_monitor (
    input wire logic mclk_in, sys_rst_in, ce_in, reg_wr_in, primary_diff_en_in, backup_diff_en_in, clock_fail_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [1:0] fb_path_out,
    input wire logic zd_rx_enable_out, zd_rx_diff_out, zd_se_pin_sel_out, primary_se_pin_sel_out,
    input wire logic backup_se_pin_sel_out, backup_rdiv_share_out, oscillator_control_midsupply_out
);
    logic [7:0] d1, d2;
    wire logic wz = reg_wr_in && ce_in && reg_addr_in == pllsel_pkg::ADDR_ZD_RX_MODE;
    wire logic wm = reg_wr_in && ce_in && reg_addr_in == pllsel_pkg::ADDR_MISC_CTRL;
    always_ff @(posedge mclk_in) {d2, d1} <= {d1, reg_wdata_in};
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    sequence sz; wz ##1 (ce_in && !wz); endsequence
    sequence sm; wm ##1 (ce_in && !wm); endsequence
    AST_FB_PATH: assert property (sz |=> fb_path_out == (d2[4] ? 2'h0 : d2[5] ? 2'h2 : 2'h1))
        else $error("feedback path wrong");
    AST_ZD_EN: assert property (sz |=> zd_rx_enable_out == (~d2[4] & ~d2[5])) else $error("zd enable");
    AST_ZD_DIFF: assert property (sz |=> zd_rx_diff_out == d2[2]) else $error("zd diff");
    AST_ZD_SE: assert property (sz |=> zd_se_pin_sel_out == (d2[3] & ~d2[2])) else $error("zd pin");
    AST_PR_SE: assert property (sz |=> primary_se_pin_sel_out == (d2[0] & ~$past(primary_diff_en_in)))
        else $error("primary pin");
    AST_BK_SE: assert property (sz |=> backup_se_pin_sel_out == (d2[1] & ~$past(backup_diff_en_in)))
        else $error("backup pin");
    AST_RDIV: assert property (sm |=> backup_rdiv_share_out == d2[7]) else $error("divider share");
    AST_MID: assert property (oscillator_control_midsupply_out |-> $past(clock_fail_in, 2) || $past(clock_fail_in, 3))
        else $error("midsupply without fail");
endmodule : pllsel_monitor
bind pllsel_top pllsel_monitor pllsel_monitor_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr_in), .primary_diff_en_in(primary_diff_en_in), .backup_diff_en_in(backup_diff_en_in),
    .clock_fail_in(clock_fail_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .fb_path_out(fb_path_out),
    .zd_rx_enable_out(zd_rx_enable_out), .zd_rx_diff_out(zd_rx_diff_out), .zd_se_pin_sel_out(zd_se_pin_sel_out),
    .primary_se_pin_sel_out(primary_se_pin_sel_out), .backup_se_pin_sel_out(backup_se_pin_sel_out),
    .backup_rdiv_share_out(backup_rdiv_share_out),
    .oscillator_control_midsupply_out(oscillator_control_midsupply_out));

// ---- sim/pllsel_ref_model.sv ----
// Purpose: reference sources, select pin and clock monitor facing pllsel_top
// Assumes: cmd_in changes between edges
// Notes: lines change only on mclk_in rising edges
`timescale 1ns/1ns
module pllsel_ref_model (
    input wire logic mclk_in,
    input wire logic [3:0] cmd_in,
    output logic ref_sel_pin_out, primary_lost_out, backup_lost_out, clock_fail_out
);
    initial {ref_sel_pin_out, primary_lost_out, backup_lost_out, clock_fail_out} = 4'h0;
    always @(posedge mclk_in) {ref_sel_pin_out, primary_lost_out, backup_lost_out, clock_fail_out} <= cmd_in;
endmodule : pllsel_ref_model

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for pllsel_top
// Assumes: ce_in high outside the clock enable test
// Notes: random receiver settings plus a table of selection corners
`timescale 1ns/1ns
module testbench;
    logic mclk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic primary_diff_en_in = 1'b0, backup_diff_en_in = 1'b0;
    logic ref_sel_pin_in, primary_lost_in, backup_lost_in, clock_fail_in, zd_rx_enable_out, zd_rx_diff_out;
    logic zd_se_pin_sel_out, primary_se_pin_sel_out, backup_diff_out, backup_se_pin_sel_out, backup_rdiv_share_out;
    logic oscillator_control_midsupply_out, active_backup_out;
    logic [9:0] reg_addr_in = 10'h000;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, d;
    logic [1:0] fb_path_out;
    logic [3:0] cmd = 4'h0;
    logic [13:0] tbl [11] = '{{8'h0c, 4'h0, 2'h2}, {8'h08, 4'h0, 2'h0}, {8'h10, 4'h8, 2'h2}, {8'h1c, 4'h0, 2'h0},
        {8'h00, 4'h4, 2'h2}, {8'h00, 4'h0, 2'h2}, {8'h04, 4'h0, 2'h0}, {8'hc0, 4'h1, 2'h1}, {8'h40, 4'h0, 2'h0},
        {8'h00, 4'h4, 2'h2}, {8'h00, 4'h2, 2'h0}};
    int failures = 0, compares = 0, cyc = 0;
    pllsel_top pllsel_top_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .primary_diff_en_in(primary_diff_en_in), .backup_diff_en_in(backup_diff_en_in),
        .ref_sel_pin_in(ref_sel_pin_in), .primary_lost_in(primary_lost_in), .backup_lost_in(backup_lost_in),
        .clock_fail_in(clock_fail_in), .fb_path_out(fb_path_out), .zd_rx_enable_out(zd_rx_enable_out),
        .zd_rx_diff_out(zd_rx_diff_out), .zd_se_pin_sel_out(zd_se_pin_sel_out),
        .primary_se_pin_sel_out(primary_se_pin_sel_out), .backup_diff_out(backup_diff_out),
        .backup_se_pin_sel_out(backup_se_pin_sel_out), .backup_rdiv_share_out(backup_rdiv_share_out),
        .oscillator_control_midsupply_out(oscillator_control_midsupply_out), .active_backup_out(active_backup_out));
    pllsel_ref_model pllsel_ref_model_inst (.mclk_in(mclk_in), .cmd_in(cmd), .ref_sel_pin_out(ref_sel_pin_in),
        .primary_lost_out(primary_lost_in), .backup_lost_out(backup_lost_in), .clock_fail_out(clock_fail_in));
    initial forever #50 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            tally_and_finish();
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge mclk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
        @(posedge mclk_in) reg_wr_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #10;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge mclk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge mclk_in) reg_rd_in <= 1'b0;
        #10 chk(reg_rdata_out, e);
    endtask : rd
    function automatic logic [7:0] exp_zd(input logic [7:0] v, input logic p, input logic b);
        return {v[4] ? 2'h0 : v[5] ? 2'h2 : 2'h1, ~v[4] & ~v[5], v[2], v[3] & ~v[2], v[0] & ~p, v[1] & ~b, b};
    endfunction : exp_zd
    task tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        void'($urandom(67));
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #10 chk({fb_path_out, zd_rx_enable_out}, 8'h03);
        rd(10'h01c, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'h10 : (i == 1) ? 8'h20 : (i == 2) ? 8'h30 : 8'($urandom);
            @(posedge mclk_in) {primary_diff_en_in, backup_diff_en_in} <= 2'($urandom);
            wr(10'h01b, d);
            chk({fb_path_out, zd_rx_enable_out, zd_rx_diff_out, zd_se_pin_sel_out, primary_se_pin_sel_out,
                backup_se_pin_sel_out, backup_diff_out}, exp_zd(d, primary_diff_en_in, backup_diff_en_in));
            rd(10'h01b, d & pllsel_pkg::ZD_RX_MASK);
        end
        wr(10'h01d, 8'hff);
        rd(10'h01d, 8'h00);
        $display("test receiver modes done");
        for (int i = 0; i < 11; i++) begin
            @(posedge mclk_in) cmd <= tbl[i][5:2];
            wr(10'h01c, tbl[i][13:6]);
            repeat (4) @(posedge mclk_in);
            #10 chk({backup_rdiv_share_out, active_backup_out, oscillator_control_midsupply_out}, {tbl[i][13], tbl[i][1:0]});
            rd(10'h01c, tbl[i][13:6] & pllsel_pkg::MISC_MASK);
        end
        $display("test selection done");
        @(posedge mclk_in) ce_in <= 1'b0;
        wr(10'h01c, 8'h9c);
        chk({7'h00, backup_rdiv_share_out}, 8'h00);
        @(posedge mclk_in) ce_in <= 1'b1;
        rd(10'h01c, 8'h00);
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule : testbench
